// [adcp_parser.sv]
// ASCII command interpreter for two relay outputs and two sensed inputs.
// Assumes a socket layer that delivers received bytes and accepts
// transmit bytes with valid/ready, and reports when a client connects.
`timescale 1ns/100ps
module adcp_parser (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  rx_data,           // Received command byte
    input  wire logic        rx_valid,          // Byte present this cycle
    input  wire logic        conn_open,         // Pulse: host opened the I/O socket
    input  wire logic [15:0] cfg_port,          // Port number from configuration
    input  wire logic        cfg_port_use,      // High selects cfg_port over default
    input  wire logic        sensed_input_first,  // Live level, low when active
    input  wire logic        sensed_input_second, // Live level, low when active
    output logic      [7:0]  tx_data,           // Status character
    output logic             tx_valid,          // Character offered
    input  wire logic        tx_ready,          // Socket layer takes it
    output logic      [15:0] listen_port,       // Port the TCP server listens on
    output logic             relay_first_n,     // Relay 1 drive, low active
    output logic             relay_second_n     // Relay 2 drive, low active
);
    // Output latch and command holding registers
    logic [7:0]  out_r, out_nxt;           // Driven image bits (inputs ignored)
    logic [7:0]  c0_r, c0_nxt;             // First command character
    logic [7:0]  c1_r, c1_nxt;             // Second
    logic [7:0]  c2_r, c2_nxt;             // Third (level)
    logic [1:0]  cnt_r, cnt_nxt;           // Characters held
    logic        ovf_r, ovf_nxt;           // Too many characters before Enter
    logic        pend_r, pend_nxt;         // Status report owed
    adcp_pkg::adcp_tx_t st_r, st_nxt;      // Transmit state
    logic [3:0]  idx_r, idx_nxt;           // Character being sent
    logic [7:0]  snap_r, snap_nxt;         // Image captured at send start
    logic [7:0]  txd_r, txd_nxt;           // Registered character
    logic [15:0] port_r, port_nxt;         // Listen port
    logic [7:0]  image;                    // Live image, bit 0 is line 1
    logic        enter;                    // Enter seen on the receive side
    logic        cmd_ok;                   // Command is legal
    logic        done;                     // Last character accepted

    always_comb begin
        image                       = out_r;
        image[adcp_pkg::SENSE1_IDX] = sensed_input_first;
        image[adcp_pkg::SENSE2_IDX] = sensed_input_second;
    end

    // CR and LF each count as Enter, so a CR LF pair asks for two reports
    assign enter = rx_valid && (rx_data == adcp_pkg::CH_CR || rx_data == adcp_pkg::CH_LF);
    // Commands longer than three characters are refused whole, never cut short
    // only lines 07/08 with level 0/1 are legal
    assign cmd_ok = !ovf_r && cnt_r == adcp_pkg::CNT_FULL && c0_r == adcp_pkg::CH_ZERO
                    && (c1_r == adcp_pkg::CH_SEVEN || c1_r == adcp_pkg::CH_EIGHT)
                    && (c2_r == adcp_pkg::CH_ZERO || c2_r == adcp_pkg::CH_ONE);
    assign done = st_r == adcp_pkg::ADCP_SEND && tx_ready && idx_r == adcp_pkg::TX_LAST;

    // Receive and execute commands
    always_comb begin
        out_nxt = out_r;
        c0_nxt  = c0_r;
        c1_nxt  = c1_r;
        c2_nxt  = c2_r;
        cnt_nxt = cnt_r;
        ovf_nxt = ovf_r;
        if (enter) begin
            // first two chars line, third level
            if (cmd_ok) begin
                // level digit lands directly, active low
                if (c1_r == adcp_pkg::CH_SEVEN)
                    out_nxt[adcp_pkg::RELAY1_IDX] = c2_r[0];
                else
                    out_nxt[adcp_pkg::RELAY2_IDX] = c2_r[0];
            end
            cnt_nxt = adcp_pkg::CNT_ZERO;
            ovf_nxt = 1'b0;
        end else if (rx_valid) begin
            // Stray characters past the third spoil the command
            unique case (cnt_r)
                2'h0:    c0_nxt = rx_data;
                2'h1:    c1_nxt = rx_data;
                2'h2:    c2_nxt = rx_data;
                adcp_pkg::CNT_FULL: ovf_nxt = 1'b1;
            endcase
            if (cnt_r != adcp_pkg::CNT_FULL)
                cnt_nxt = cnt_r + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            out_r <= adcp_pkg::IMAGE_RESET;
            c0_r  <= 8'h00;
            c1_r  <= 8'h00;
            c2_r  <= 8'h00;
            cnt_r <= adcp_pkg::CNT_ZERO;
            ovf_r <= 1'b0;
        end else begin
            out_r <= out_nxt;
            c0_r  <= c0_nxt;
            c1_r  <= c1_nxt;
            c2_r  <= c2_nxt;
            cnt_r <= cnt_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    // Report scheduling and character transmit
    always_comb begin
        pend_nxt = pend_r;
        st_nxt   = st_r;
        idx_nxt  = idx_r;
        snap_nxt = snap_r;
        txd_nxt  = txd_r;
        // new request wins over the clear on send start
        if (st_r == adcp_pkg::ADCP_IDLE && pend_r) begin
            st_nxt   = adcp_pkg::ADCP_SEND;
            snap_nxt = image;
            idx_nxt  = 4'h0;
            txd_nxt  = image[0] ? adcp_pkg::CH_ONE : adcp_pkg::CH_ZERO;
            pend_nxt = 1'b0;
        end else if (st_r == adcp_pkg::ADCP_SEND && tx_ready) begin
            if (done) begin
                st_nxt = adcp_pkg::ADCP_IDLE;
            end else begin
                // line 1 first, line 8 last
                idx_nxt = idx_r + 4'h1;
                txd_nxt = snap_r[idx_r[2:0] + 3'h1] ? adcp_pkg::CH_ONE : adcp_pkg::CH_ZERO;
            end
        end
        // Requests that arrive while busy merge into one owed report
        if (enter || conn_open)
            pend_nxt = 1'b1;
    end

    // Transmit state and character registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            pend_r <= 1'b0;
            st_r   <= adcp_pkg::ADCP_IDLE;
            idx_r  <= 4'h0;
            snap_r <= adcp_pkg::IMAGE_RESET;
            txd_r  <= adcp_pkg::CH_ONE;
        end else begin
            pend_r <= pend_nxt;
            st_r   <= st_nxt;
            idx_r  <= idx_nxt;
            snap_r <= snap_nxt;
            txd_r  <= txd_nxt;
        end
    end

    always_comb begin
        port_nxt = cfg_port_use ? cfg_port : adcp_pkg::PORT_DEFAULT;
    end

    // Listen port register
    always_ff @(posedge mclk) begin
        if (rst)
            port_r <= adcp_pkg::PORT_DEFAULT;
        else
            port_r <= port_nxt;
    end

    assign tx_data        = txd_r;
    assign tx_valid       = st_r == adcp_pkg::ADCP_SEND;
    assign listen_port    = port_r;
    // relays on lines 7 and 8
    assign relay_first_n  = out_r[adcp_pkg::RELAY1_IDX];
    assign relay_second_n = out_r[adcp_pkg::RELAY2_IDX];

    // Assertions
    a_reset_image: assert property (@(posedge mclk) $past(rst) && !rst |->
        relay_first_n && relay_second_n) else $error("outputs not inactive after reset");
    a_relay_act: assert property (@(posedge mclk) disable iff (rst)
        enter && cmd_ok && c1_r == adcp_pkg::CH_SEVEN |=> relay_first_n == $past(c2_r[0]))
        else $error("relay 1 not set by command");
    a_bad_ignored: assert property (@(posedge mclk) disable iff (rst)
        enter && !cmd_ok |=> $stable(out_r)) else $error("illegal command changed outputs");
    a_cmd_report: assert property (@(posedge mclk) disable iff (rst)
        enter |=> pend_r || st_r == adcp_pkg::ADCP_SEND) else $error("no report after command");
    a_open_report: assert property (@(posedge mclk) disable iff (rst)
        conn_open && st_r == adcp_pkg::ADCP_IDLE |=> ##[0:2] tx_valid)
        else $error("no report on connect");
    // Snapshot must carry the sensed pins as they stood at send start
    a_input_live: assert property (@(posedge mclk) disable iff (rst)
        st_r == adcp_pkg::ADCP_IDLE && pend_r |=>
        snap_r[adcp_pkg::SENSE1_IDX] == $past(sensed_input_first)
        && snap_r[adcp_pkg::SENSE2_IDX] == $past(sensed_input_second))
        else $error("input not live");
    a_char_legal: assert property (@(posedge mclk) disable iff (rst)
        tx_valid |-> tx_data == adcp_pkg::CH_ZERO || tx_data == adcp_pkg::CH_ONE)
        else $error("illegal status character");
    a_port_default: assert property (@(posedge mclk) disable iff (rst)
        !cfg_port_use |=> listen_port == adcp_pkg::PORT_DEFAULT) else $error("port not 101");
    // Line 08 commands reach the second relay
    a_relay_map: assert property (@(posedge mclk) disable iff (rst)
        enter && cmd_ok && c1_r == adcp_pkg::CH_EIGHT |=> relay_second_n == $past(c2_r[0]))
        else $error("relay 2 mapping");
    // A command taken while idle is answered two edges later
    a_cmd_answer: assert property (@(posedge mclk) disable iff (rst)
        enter && st_r == adcp_pkg::ADCP_IDLE && !pend_r |-> ##2 tx_valid)
        else $error("status not offered after command");
    // A refused offer stands unchanged until taken
    a_char_hold: assert property (@(posedge mclk) disable iff (rst)
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("status character dropped while stalled");

    // Main scenarios
    c_cmd_ok: cover property (@(posedge mclk) enter && cmd_ok);
    c_cmd_bad: cover property (@(posedge mclk) enter && !cmd_ok);
    c_send_done: cover property (@(posedge mclk) done);
    c_stall: cover property (@(posedge mclk) tx_valid && !tx_ready);
    c_open: cover property (@(posedge mclk) conn_open);
endmodule

// [adcp_pkg.sv]
// Package for the ASCII digital I/O command parser.
// Assumes a byte stream from a socket layer outside this block.
package adcp_pkg;
    localparam int          LINES        = 8;          // Lines in the I/O image
    localparam logic [7:0]  IMAGE_RESET  = 8'hff;      // All lines inactive high
    localparam int          RELAY1_IDX   = 6;          // Line 07, bit index from line 1
    localparam int          RELAY2_IDX   = 7;          // Line 08
    localparam int          SENSE1_IDX   = 4;          // Line 05
    localparam int          SENSE2_IDX   = 5;          // Line 06
    localparam logic [7:0]  CH_ZERO      = 8'h30;      // ASCII '0'
    localparam logic [7:0]  CH_ONE       = 8'h31;      // ASCII '1'
    localparam logic [7:0]  CH_SEVEN     = 8'h37;      // ASCII '7'
    localparam logic [7:0]  CH_EIGHT     = 8'h38;      // ASCII '8'
    localparam logic [7:0]  CH_CR        = 8'h0d;      // Enter key
    localparam logic [7:0]  CH_LF        = 8'h0a;      // Line feed, also ends a command
    localparam logic [15:0] PORT_DEFAULT = 16'h0065;   // Socket port 101
    localparam logic [3:0]  TX_LAST      = 4'h7;       // Index of last status character
    localparam logic [1:0]  CNT_ZERO     = 2'h0;
    localparam logic [1:0]  CNT_FULL     = 2'h3;       // Three command characters held
    typedef enum logic [0:0] {ADCP_IDLE, ADCP_SEND} adcp_tx_t;
endpackage

// [adcp_host.sv]
// Host terminal model: types commands and collects the status strings.
// Assumes the parser runs on the same clock; it drives at the falling edge.
`timescale 1ns/100ps
module adcp_host (
    input  wire logic       mclk,
    input  wire logic       slow,      // High: host stalls every other cycle
    input  wire logic [7:0] tx_data,   // Status character from the device
    input  wire logic       tx_valid,  // Character offered
    output logic      [7:0] rx_data,   // Typed character
    output logic            rx_valid,  // Character present
    output logic            conn_open, // Socket opened
    output logic            tx_ready   // Host takes a character
);
    logic [7:0] img;     // Last eight characters, line 1 in the top bit
    logic       bad;     // A character other than '0' or '1' was seen
    int         n_chars; // Characters taken so far
    initial begin
        rx_data   = 8'h00;
        rx_valid  = 1'b0;
        conn_open = 1'b0;
        tx_ready  = 1'b1;
        img       = 8'h00;
        bad       = 1'b0;
        n_chars   = 0;
    end
    // Pacing: a slow host refuses half the offers, so stalls are exercised
    always @(negedge mclk) tx_ready <= slow ? ~tx_ready : 1'b1;
    always @(posedge mclk) begin
        if (tx_valid && tx_ready) begin
            img     <= {img[6:0], tx_data == adcp_pkg::CH_ONE};
            bad     <= bad | (tx_data != adcp_pkg::CH_ONE && tx_data != adcp_pkg::CH_ZERO);
            n_chars <= n_chars + 1;
        end
    end
    task automatic type_line(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] c2);
        logic [7:0] seq [4];
        seq = '{c0, c1, c2, adcp_pkg::CH_CR};
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            rx_data  = seq[i];
            rx_valid = 1'b1;
        end
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data; // Released line shows no stale byte
    endtask
    // four characters then line feed: one character too many
    task automatic type_long(input logic [7:0] c0, input logic [7:0] c1,
                             input logic [7:0] c2, input logic [7:0] c3);
        logic [7:0] seq [5];
        seq = '{c0, c1, c2, c3, adcp_pkg::CH_LF};
        for (int i = 0; i < 5; i++) begin
            @(negedge mclk);
            rx_data  = seq[i];
            rx_valid = 1'b1;
        end
        @(negedge mclk);
        rx_valid = 1'b0;
        rx_data  = ~rx_data; // Released line shows no stale byte
    endtask
    // One-cycle notice that the socket opened
    task automatic open_link();
        @(negedge mclk);
        conn_open = 1'b1;
        @(negedge mclk);
        conn_open = 1'b0;
    endtask
endmodule

// [adcp_parser_test.sv]
// Self-checking bench for the command parser with a host terminal model.
// Assumes nothing beyond the parser, its package and the host model.
`timescale 1ns/100ps
module adcp_parser_test;
    logic        mclk, rst, rx_valid, conn_open, cfg_port_use, tx_valid, tx_ready, slow;
    logic        sensed_input_first, sensed_input_second, relay_first_n, relay_second_n;
    logic [7:0]  rx_data, tx_data;
    logic [15:0] cfg_port, listen_port;
    int          mismatches, total_checks;
    adcp_parser uut (.mclk(mclk), .rst(rst), .rx_data(rx_data), .rx_valid(rx_valid),
        .conn_open(conn_open), .cfg_port(cfg_port), .cfg_port_use(cfg_port_use),
        .sensed_input_first(sensed_input_first), .sensed_input_second(sensed_input_second),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .listen_port(listen_port),
        .relay_first_n(relay_first_n), .relay_second_n(relay_second_n));
    adcp_host host (.mclk(mclk), .slow(slow), .tx_data(tx_data), .tx_valid(tx_valid),
        .rx_data(rx_data), .rx_valid(rx_valid), .conn_open(conn_open), .tx_ready(tx_ready));
    // Free-running 25 MHz clock
    always #20 mclk = ~mclk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Waits, bounded, for one whole status string and compares it
    task automatic expect_status(input logic [7:0] exp, input logic [1:0] relays);
        int start;
        start = host.n_chars;
        for (int i = 0; i < 400 && host.n_chars < start + 8; i++) @(negedge mclk);
        check(16'(host.n_chars - start), 16'h0008);
        check({8'h00, host.img}, {8'h00, exp});
        check({15'h0000, host.bad}, 16'h0000);
        check({14'h0000, relay_first_n, relay_second_n}, {14'h0000, relays});
    endtask
    // Scenarios: connect, set, stall, sense, refuse, release
    task automatic run_all();
        host.open_link();
        expect_status(8'hff, 2'b11);
        check(listen_port, 16'h0065);
        host.type_line(adcp_pkg::CH_ZERO, adcp_pkg::CH_SEVEN, adcp_pkg::CH_ZERO);
        expect_status(8'hfd, 2'b01);
        slow = 1'b1;
        host.type_line(adcp_pkg::CH_ZERO, adcp_pkg::CH_EIGHT, adcp_pkg::CH_ZERO);
        expect_status(8'hfc, 2'b00);
        slow = 1'b0;
        sensed_input_first = 1'b0;
        host.type_line(adcp_pkg::CH_ZERO, adcp_pkg::CH_EIGHT, adcp_pkg::CH_ONE);
        expect_status(8'hf5, 2'b01);
        host.type_line(adcp_pkg::CH_ZERO, 8'h35, adcp_pkg::CH_ZERO);
        expect_status(8'hf5, 2'b01);
        host.type_line(adcp_pkg::CH_ZERO, adcp_pkg::CH_SEVEN, 8'h32);
        expect_status(8'hf5, 2'b01);
        host.type_long(adcp_pkg::CH_ZERO, adcp_pkg::CH_EIGHT,
                       adcp_pkg::CH_ZERO, adcp_pkg::CH_ONE);
        expect_status(8'hf5, 2'b01);
        sensed_input_first  = 1'b1;
        sensed_input_second = 1'b0;
        cfg_port_use        = 1'b1;
        host.type_line(adcp_pkg::CH_ZERO, adcp_pkg::CH_SEVEN, adcp_pkg::CH_ONE);
        expect_status(8'hfb, 2'b11);
        check(listen_port, 16'h1234);
    endtask
    // Reset for 20 cycles, then the scenarios
    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        slow = 1'b0;
        cfg_port = 16'h1234;
        cfg_port_use = 1'b0;
        sensed_input_first = 1'b1;
        sensed_input_second = 1'b1;
        mismatches = 0;
        total_checks = 0;
        repeat (20) @(negedge mclk);
        rst = 1'b0;
        run_all();
        final_report();
    end
    // Watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #400000;
        mismatches++;
        final_report();
    end
endmodule
